// ==== design/ppc_pkg.sv ====
package ppc_pkg;

  // ****************************************************
  // register indices (byte addresses on the plain port)
  // ****************************************************
  localparam logic [3:0] ADDR_DIRECTION = 4'h0;
  localparam logic [3:0] ADDR_OUT_VALUE = 4'h1;
  localparam logic [3:0] ADDR_WEAK_DRIVE = 4'h2;
  localparam logic [3:0] ADDR_PULL_ENABLE = 4'h3;
  localparam logic [3:0] ADDR_PULL_POLARITY = 4'h4;
  localparam logic [3:0] ADDR_EDGE_IRQ_ENABLE = 4'h5;
  localparam logic [3:0] ADDR_PIN_LEVEL = 4'h6;
  localparam logic [3:0] ADDR_EDGE_FLAGS = 4'h7;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
  localparam logic [3:0] ADDR_RESERVED = 4'h9;
  localparam logic [3:0] ADDR_CHANNEL_REROUTE = 4'hA;
  localparam logic [3:0] ADDR_ANALOG_DIRECTION = 4'hB;
  localparam logic [3:0] ADDR_ANALOG_WEAK_DRIVE = 4'hC;

  // ****************************************************
  // reset values
  // ****************************************************
  localparam logic [7:0] RESET_ZERO = 8'h00;
  localparam logic [7:0] RESERVED_READ = 8'h00;

  // ****************************************************
  // pull device encoding per pin
  // ****************************************************
  typedef enum logic [1:0] {
    PPC_PULL_NONE,
    PPC_PULL_UP,
    PPC_PULL_DOWN
  } ppc_pull_t;

endpackage

// ==== design/ppc_port_pin_config.sv ====
`timescale 1ns/1ps

// Behaviour
// - A direction bit of 1 makes its pin an output, 0 makes it an input.
// - An input pin gets a pull device only while its pull enable bit is set.
// - Pull polarity 1 picks a pull-down, 0 a pull-up, for an enabled input pull.
// - An output pin never has its pull device enabled, whatever the pull bits hold.
// - With edge interrupt enabled, polarity 0 detects falling and 1 rising edges, any direction.
// - Only ports built with edge capability carry an edge interrupt enable.
// - On ports without selectable polarity the polarity control reads 0, so only pull-ups exist.
// - An output pin is driven to the level of its output value bit.
// - Weak drive 1 gives reduced strength and 0 full, with no effect on an input pin.
// - Weak drive applies whatever function is currently driving the pin.
// - The reserved register reads zero and ignores writes.
// - The channel reroute register is readable and writable at any time and steers channels.
// - Every register bit is read as a value synchronous to the internal clock.
module ppc_port_pin_config #(
  parameter int WIDTH = 8,
  parameter bit HAS_EDGE_IRQ = 1'b1,
  parameter bit HAS_POLARITY = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe_n,
  output logic [WIDTH-1:0] pin_weak_drive,
  output logic [WIDTH-1:0] pin_pull_up,
  output logic [WIDTH-1:0] pin_pull_down,
  output logic [7:0] channel_reroute,
  output logic [7:0] analog_direction,
  output logic [7:0] analog_weak_drive,
  output logic irq
);

  // ****************************************************
  // elaboration check
  // ****************************************************
  if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
    $error("WIDTH must be 1 to 8");
  end

  // ****************************************************
  // reset release
  // ****************************************************
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ****************************************************
  // configuration registers
  // ****************************************************
  logic [WIDTH-1:0] direction;
  logic [WIDTH-1:0] out_value;
  logic [WIDTH-1:0] weak_drive_select;
  logic [WIDTH-1:0] pull_enable;
  logic [WIDTH-1:0] pull_polarity;
  logic [WIDTH-1:0] edge_irq_enable;
  logic [WIDTH-1:0] irq_mask;
  logic [7:0] port_t_channel_reroute;
  logic [7:0] analog_port_direction_hi;
  logic [7:0] analog_port_weak_drive_lo;

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      direction <= '0;
      out_value <= '0;
      weak_drive_select <= '0;
      pull_enable <= '0;
      pull_polarity <= '0;
      edge_irq_enable <= '0;
      irq_mask <= '0;
      port_t_channel_reroute <= ppc_pkg::RESET_ZERO;
      analog_port_direction_hi <= ppc_pkg::RESET_ZERO;
      analog_port_weak_drive_lo <= ppc_pkg::RESET_ZERO;
    end else if (reg_write) begin
      if (reg_addr == ppc_pkg::ADDR_DIRECTION) begin
        direction <= reg_wdata[WIDTH-1:0];
      end else if (reg_addr == ppc_pkg::ADDR_OUT_VALUE) begin
        out_value <= reg_wdata[WIDTH-1:0];
      end else if (reg_addr == ppc_pkg::ADDR_WEAK_DRIVE) begin
        weak_drive_select <= reg_wdata[WIDTH-1:0];
      end else if (reg_addr == ppc_pkg::ADDR_PULL_ENABLE) begin
        pull_enable <= reg_wdata[WIDTH-1:0];
      end else if (reg_addr == ppc_pkg::ADDR_PULL_POLARITY) begin
        // fixed ports keep the bit at zero: pull-up only
        pull_polarity <= HAS_POLARITY ? reg_wdata[WIDTH-1:0] : '0;
      end else if (reg_addr == ppc_pkg::ADDR_EDGE_IRQ_ENABLE) begin
        edge_irq_enable <= HAS_EDGE_IRQ ? reg_wdata[WIDTH-1:0] : '0;
      end else if (reg_addr == ppc_pkg::ADDR_IRQ_MASK) begin
        irq_mask <= reg_wdata[WIDTH-1:0];
      end else if (reg_addr == ppc_pkg::ADDR_CHANNEL_REROUTE) begin
        port_t_channel_reroute <= reg_wdata;
      end else if (reg_addr == ppc_pkg::ADDR_ANALOG_DIRECTION) begin
        analog_port_direction_hi <= reg_wdata;
      end else if (reg_addr == ppc_pkg::ADDR_ANALOG_WEAK_DRIVE) begin
        analog_port_weak_drive_lo <= reg_wdata;
      end
    end
  end

  // ****************************************************
  // pin input synchroniser and edge detection
  // ****************************************************
  logic [WIDTH-1:0] pin_meta;
  logic [WIDTH-1:0] pin_sync;
  logic [WIDTH-1:0] pin_prev;
  logic [WIDTH-1:0] edge_seen;
  logic [WIDTH-1:0] edge_flags;
  logic flags_read;

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign flags_read = reg_read && (reg_addr == ppc_pkg::ADDR_EDGE_FLAGS);

  genvar gi;
  for (gi = 0; gi < WIDTH; gi++) begin : g_edge
    // polarity 0 falling, 1 rising; direction does not matter
    assign edge_seen[gi] = edge_irq_enable[gi] &&
      (pull_polarity[gi] ? (pin_sync[gi] && !pin_prev[gi])
                         : (!pin_sync[gi] && pin_prev[gi]));
  end

  // read clears; a new edge in the same cycle wins
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      edge_flags <= '0;
    end else begin
      edge_flags <= (flags_read ? '0 : edge_flags) | edge_seen;
    end
  end

  // ****************************************************
  // pin drive and pull devices
  // ****************************************************
  logic [WIDTH-1:0] next_pull_up;
  logic [WIDTH-1:0] next_pull_down;

  assign next_pull_up = ~direction & pull_enable & ~pull_polarity;
  assign next_pull_down = ~direction & pull_enable & pull_polarity;

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_out <= '0;
      pin_oe_n <= '1;
      pin_weak_drive <= '0;
      pin_pull_up <= '0;
      pin_pull_down <= '0;
      channel_reroute <= ppc_pkg::RESET_ZERO;
      analog_direction <= ppc_pkg::RESET_ZERO;
      analog_weak_drive <= ppc_pkg::RESET_ZERO;
      irq <= 1'b0;
    end else begin
      pin_out <= out_value;
      pin_oe_n <= ~direction;
      // strength follows the pin, not the function driving it
      pin_weak_drive <= weak_drive_select & direction;
      pin_pull_up <= next_pull_up;
      pin_pull_down <= next_pull_down;
      channel_reroute <= port_t_channel_reroute;
      analog_direction <= analog_port_direction_hi;
      analog_weak_drive <= analog_port_weak_drive_lo & analog_port_direction_hi;
      irq <= |(((flags_read ? '0 : edge_flags) | edge_seen) & irq_mask);
    end
  end

  // ****************************************************
  // register read port
  // ****************************************************
  logic [7:0] next_rdata;

  // all read sources are flops of this clock
  always_comb begin
    next_rdata = 8'h00;
    if (reg_addr == ppc_pkg::ADDR_DIRECTION) begin
      next_rdata[WIDTH-1:0] = direction;
    end else if (reg_addr == ppc_pkg::ADDR_OUT_VALUE) begin
      next_rdata[WIDTH-1:0] = out_value;
    end else if (reg_addr == ppc_pkg::ADDR_WEAK_DRIVE) begin
      next_rdata[WIDTH-1:0] = weak_drive_select;
    end else if (reg_addr == ppc_pkg::ADDR_PULL_ENABLE) begin
      next_rdata[WIDTH-1:0] = pull_enable;
    end else if (reg_addr == ppc_pkg::ADDR_PULL_POLARITY) begin
      next_rdata[WIDTH-1:0] = pull_polarity;
    end else if (reg_addr == ppc_pkg::ADDR_EDGE_IRQ_ENABLE) begin
      next_rdata[WIDTH-1:0] = edge_irq_enable;
    end else if (reg_addr == ppc_pkg::ADDR_PIN_LEVEL) begin
      next_rdata[WIDTH-1:0] = pin_sync;
    end else if (reg_addr == ppc_pkg::ADDR_EDGE_FLAGS) begin
      next_rdata[WIDTH-1:0] = edge_flags;
    end else if (reg_addr == ppc_pkg::ADDR_IRQ_MASK) begin
      next_rdata[WIDTH-1:0] = irq_mask;
    end else if (reg_addr == ppc_pkg::ADDR_RESERVED) begin
      next_rdata = ppc_pkg::RESERVED_READ;
    end else if (reg_addr == ppc_pkg::ADDR_CHANNEL_REROUTE) begin
      next_rdata = port_t_channel_reroute;
    end else if (reg_addr == ppc_pkg::ADDR_ANALOG_DIRECTION) begin
      next_rdata = analog_port_direction_hi;
    end else if (reg_addr == ppc_pkg::ADDR_ANALOG_WEAK_DRIVE) begin
      next_rdata = analog_port_weak_drive_lo;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

// ==== verif/ppc_pin_properties.sv ====
`timescale 1ns/1ps
// ****
// port checker
// ****
module ppc_pin_checker #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] pin_out,
  input wire logic [WIDTH-1:0] pin_oe_n,
  input wire logic [WIDTH-1:0] pin_weak_drive,
  input wire logic [WIDTH-1:0] pin_pull_up,
  input wire logic [WIDTH-1:0] pin_pull_down,
  input wire logic [7:0] channel_reroute,
  input wire logic [7:0] analog_direction,
  input wire logic [7:0] analog_weak_drive,
  input wire logic irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_rd(logic [3:0] a);
    reg_read && reg_addr == a;
  endsequence
  a_pull_exclusive: assert property (~|(pin_pull_up & pin_pull_down))
    else $error("pull up and pull down both on");
  a_output_no_pull: assert property (~|((pin_pull_up | pin_pull_down) & ~pin_oe_n))
    else $error("pull device on a driving pin");
  a_weak_output_only: assert property (~|(pin_weak_drive & pin_oe_n))
    else $error("weak drive on an input pin");
  a_analog_weak_gated: assert property (~|(analog_weak_drive & ~analog_direction))
    else $error("analog weak drive on an input pin");
  a_reserved_reads_zero: assert property (s_rd(ppc_pkg::ADDR_RESERVED) |=> reg_rdata == 8'h00)
    else $error("reserved register read nonzero");
  a_reroute_read_back: assert property (s_rd(ppc_pkg::ADDR_CHANNEL_REROUTE) |=> reg_rdata == channel_reroute)
    else $error("reroute read differs from output");
  a_direction_read_back: assert property (s_rd(ppc_pkg::ADDR_DIRECTION) |=> reg_rdata[WIDTH-1:0] == ~pin_oe_n)
    else $error("direction read differs from enables");
  a_out_read_back: assert property (s_rd(ppc_pkg::ADDR_OUT_VALUE) |=> reg_rdata[WIDTH-1:0] == pin_out)
    else $error("out value read differs from pins");
  a_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("read data without a read");
endmodule

bind ppc_port_pin_config ppc_pin_checker #(.WIDTH(WIDTH)) chk_u (.ref_clk(ref_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
  .pin_weak_drive(pin_weak_drive), .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down),
  .channel_reroute(channel_reroute), .analog_direction(analog_direction),
  .analog_weak_drive(analog_weak_drive), .irq(irq));

// ==== verif/test_port_pin_config.sv ====
`timescale 1ns/1ps
module test_port_pin_config;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] pin_in = 8'h00;
  logic [7:0] reg_rdata, pin_out, pin_oe_n, pin_weak_drive, pin_pull_up, pin_pull_down;
  logic [7:0] channel_reroute, analog_direction, analog_weak_drive;
  logic irq;
  logic [7:0] regs[16];
  logic [7:0] flags;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  int seed = 32;
  ppc_port_pin_config dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_weak_drive(pin_weak_drive),
    .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down), .channel_reroute(channel_reroute),
    .analog_direction(analog_direction), .analog_weak_drive(analog_weak_drive), .irq(irq));
  initial forever #20 ref_clk = ~ref_clk;
  // ****
  // checking and bus tasks
  // ****
  task wrap_up;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // the whole run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      wrap_up();
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_write <= 1'b0;
    if (a < 4'h6 || a == 4'h8 || (a > 4'h9 && a < 4'hD)) regs[a] = d;
  endtask
  task rd(input logic [3:0] a);
    logic [7:0] e;
    e = (a == 4'h6) ? pin_in : (a == 4'h7) ? flags : regs[a];
    @(posedge ref_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, e, "read data");
    if (a == 4'h7) flags = 8'h00;
  endtask
  task outs;
    repeat (2) @(posedge ref_clk);
    #1 chk(pin_oe_n, ~regs[0], "direction");
    chk(pin_out, regs[1], "out value");
    chk(pin_weak_drive, regs[2] & regs[0], "weak drive");
    chk(pin_pull_up, regs[3] & ~regs[0] & ~regs[4], "pull up");
    chk(pin_pull_down, regs[3] & ~regs[0] & regs[4], "pull down");
    chk(channel_reroute, regs[10], "reroute");
    chk(analog_direction, regs[11], "analog direction");
    chk(analog_weak_drive, regs[12] & regs[11], "analog weak");
  endtask
  task settle(input int n, input logic exp_irq);
    repeat (n) @(posedge ref_clk);
    #1 chk({7'h00, irq}, {7'h00, exp_irq}, "irq level");
  endtask
  initial begin
    regs = '{default: 8'h00};
    flags = 8'h00;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    for (int a = 0; a < 16; a++) rd(4'(a));
    $display("reset values done");
    repeat (40) begin
      wr(4'($random(seed)), 8'($random(seed)));
      outs();
    end
    for (int a = 0; a < 16; a++) rd(4'(a));
    $display("register access done");
    wr(4'h0, 8'h00);
    wr(4'h5, 8'hFF);
    wr(4'h4, 8'h0F);
    wr(4'h8, 8'hFF);
    @(posedge ref_clk) pin_in <= 8'hFF;
    flags = 8'h0F;
    settle(5, 1'b1);
    rd(4'h6);
    rd(4'h7);
    settle(2, 1'b0);
    wr(4'h8, 8'h00);
    @(posedge ref_clk) pin_in <= 8'h00;
    flags = 8'hF0;
    settle(5, 1'b0);
    wr(4'h8, 8'hF0);
    settle(2, 1'b1);
    rd(4'h7);
    settle(2, 1'b0);
    $display("edge interrupts done");
    wrap_up();
  end
endmodule
